/* design/opc_pump_ctrl_map.vh */
// Register map constants for the output PLL PFD and charge pump control block
`ifndef OPC_PUMP_CTRL_MAP_VH
`define OPC_PUMP_CTRL_MAP_VH

// ==========================================================================
// Register addresses
`define OPC_ADDR_PUMP_CONTROL 8'h0B
`define OPC_ADDR_PUMP_OFFSET_CONTROL 8'h0C
`define OPC_ADDR_ANTIBACKLASH_LOCK 8'h0D

// ==========================================================================
// Reset values
`define OPC_RST_PUMP_CONTROL 8'h30
`define OPC_RST_PUMP_OFFSET_CONTROL 8'h00
`define OPC_RST_ANTIBACKLASH_LOCK 8'h00

// ==========================================================================
// Writable bit masks
`define OPC_MASK_PUMP_CONTROL 8'hFF
`define OPC_MASK_PUMP_OFFSET_CONTROL 8'h7F
`define OPC_MASK_ANTIBACKLASH_LOCK 8'hC1
`define OPC_READ_ZERO 8'h00

// ==========================================================================
// Pump control fields
`define OPC_PC_CURRENT_EN 7
`define OPC_PC_ABL_EN 6
`define OPC_PC_MODE_HI 5
`define OPC_PC_MODE_LO 4
`define OPC_PC_MODE_EN 3
`define OPC_PC_FB_EDGE 2
`define OPC_PC_REF_EDGE 1
`define OPC_PC_VCO_MID 0

// ==========================================================================
// Pump offset control fields
`define OPC_OC_DIR 6
`define OPC_OC_FRAC_HI 5
`define OPC_OC_FRAC_LO 4
`define OPC_OC_EN 3
`define OPC_OC_UP_DIV2 2
`define OPC_OC_DN_DIV2 1
`define OPC_OC_FB_DIV2 0

// ==========================================================================
// Antibacklash and lock detect fields
`define OPC_AL_PERIOD_HI 7
`define OPC_AL_PERIOD_LO 6
`define OPC_AL_LOCK_PD 0

// ==========================================================================
// Encodings
`define OPC_MODE_TRISTATE 2'h0
`define OPC_MODE_PUMP_UP 2'h1
`define OPC_MODE_PUMP_DOWN 2'h2
`define OPC_MODE_NORMAL 2'h3
`define OPC_FRAC_HALF 2'h0
`define OPC_FRAC_QUARTER 2'h1
`define OPC_FRAC_EIGHTH 2'h2
`define OPC_FRAC_SIXTEENTH 2'h3
`define OPC_ABL_MINIMUM 2'h0
`define OPC_ABL_LOW 2'h1
`define OPC_ABL_HIGH 2'h2
`define OPC_ABL_MAXIMUM 2'h3

// ==========================================================================
// Register index codes
`define OPC_IDX_NONE 2'h0
`define OPC_IDX_PUMP_CONTROL 2'h1
`define OPC_IDX_PUMP_OFFSET 2'h2
`define OPC_IDX_ANTIBACKLASH 2'h3

// ==========================================================================
// Offset selection bus fields
`define OPC_SEL_DIR 2
`define OPC_SEL_FRAC_HI 1
`define OPC_SEL_FRAC_LO 0

`endif

/* design/opc_override_mux.v */
// Selects between a software setting and the device's own setting
`timescale 1ns/10ps
`default_nettype none

module opc_override_mux #(
    parameter WIDTH = 2
) (
    // Selection
    input wire overrideEnable,
    // Candidates
    input wire [WIDTH-1:0] softwareValue,
    input wire [WIDTH-1:0] autoValue,
    // Result
    output wire [WIDTH-1:0] selectedValue
);

    assign selectedValue = overrideEnable ? softwareValue : autoValue;

endmodule // opc_override_mux

`default_nettype wire

/* design/opc_pump_ctrl.v */
// Output PLL PFD and charge pump control registers with override selection
//
// Summary of operation
// - Mode field value 00 means tristate and 01 means pump up continuously.
// - Mode field value 10 means pump down, 11 means normal, and 11 is the reset value.
// - With pump control bit 3 clear the device picks the mode, with it set bits 5:4 decide.
// - Pump control bit 2 picks the feedback edge, 0 rising by default and 1 falling.
// - Pump control bit 1 picks the reference edge, 0 rising by default and 1 falling.
// - Pump control bit 0 set forces the oscillator control voltage to midscale, 0 is normal.
// - Offset bit 6 sets offset direction, 0 up by default and 1 down, only while offset bit 3 is set.
// - Offset bits 5:4 give offset current as 1/2, 1/4, 1/8 or 1/16 of pump current, only while bit 3 is set.
// - With offset bit 3 clear the device sets the offset current, with it set bits 6:4 decide.
// - Offset bits 2, 1 and 0 enable test divide-by-2 on PFD up, PFD down and feedback paths.
// - Antibacklash bits 7:6 select minimum, low, high or maximum period, minimum by default.
// - The antibacklash field applies only while pump control bit 6 is set, else the device picks.
// - Antibacklash bit 0 set powers down the lock detector, 0 keeps it active by default.
`timescale 1ns/10ps
`default_nettype none
`include "opc_pump_ctrl_map.vh"

module opc_pump_ctrl (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Register access from the serial port
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    input wire readBuffered,
    input wire ioUpdate,
    output reg [7:0] regRdData,
    output reg regAddrHit,
    // Settings chosen by the device itself
    input wire [1:0] autoPumpMode,
    input wire autoOffsetDirection,
    input wire [1:0] autoOffsetFraction,
    input wire [1:0] autoAntibacklashPeriod,
    // Analog controls
    output reg [1:0] pump_operating_mode,
    output reg pumpCurrentOverrideEnable,
    output reg feedbackEdgeFalling,
    output reg referenceEdgeFalling,
    output reg vcoForceMidscale,
    output reg pump_offset_direction,
    output reg [1:0] pump_offset_fraction,
    output reg pfdUpDiv2Enable,
    output reg pfdDownDiv2Enable,
    output reg feedbackDiv2Enable,
    output reg [1:0] antibacklashPeriod,
    output reg lockDetectPowerDown
);

    // ======================================================================
    // Buffered and active copies
    // Writes land in the buffer; ioUpdate makes them live together so
    // related fields never change one at a time.
    reg [7:0] bufPumpControl_reg;
    reg [7:0] bufOffsetControl_reg;
    reg [7:0] bufAntibacklash_reg;
    reg [7:0] actPumpControl_reg;
    reg [7:0] actOffsetControl_reg;
    reg [7:0] actAntibacklash_reg;

    // Write merge keeps unused bits at zero
    function [7:0] maskWrite;
        input [7:0] data;
        input [7:0] mask;
        begin
            maskWrite = data & mask;
        end
    endfunction

    // Address decode shared by the write and read paths
    function [1:0] regIndex;
        input [7:0] addr;
        begin
            case (addr)
                `OPC_ADDR_PUMP_CONTROL: regIndex = `OPC_IDX_PUMP_CONTROL;
                `OPC_ADDR_PUMP_OFFSET_CONTROL: regIndex = `OPC_IDX_PUMP_OFFSET;
                `OPC_ADDR_ANTIBACKLASH_LOCK: regIndex = `OPC_IDX_ANTIBACKLASH;
                default: regIndex = `OPC_IDX_NONE;
            endcase
        end
    endfunction

    wire [1:0] accessIndex;
    assign accessIndex = regIndex(regAddr);

    always @(posedge ref_clk) begin
        if (rst) begin
            bufPumpControl_reg <= `OPC_RST_PUMP_CONTROL;
            bufOffsetControl_reg <= `OPC_RST_PUMP_OFFSET_CONTROL;
            bufAntibacklash_reg <= `OPC_RST_ANTIBACKLASH_LOCK;
        end else if (regWrEn) begin
            case (accessIndex)
                `OPC_IDX_PUMP_CONTROL: begin
                    bufPumpControl_reg <= maskWrite(regWrData, `OPC_MASK_PUMP_CONTROL);
                end
                `OPC_IDX_PUMP_OFFSET: begin
                    bufOffsetControl_reg <= maskWrite(regWrData, `OPC_MASK_PUMP_OFFSET_CONTROL);
                end
                `OPC_IDX_ANTIBACKLASH: begin
                    bufAntibacklash_reg <= maskWrite(regWrData, `OPC_MASK_ANTIBACKLASH_LOCK);
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            actPumpControl_reg <= `OPC_RST_PUMP_CONTROL;
            actOffsetControl_reg <= `OPC_RST_PUMP_OFFSET_CONTROL;
            actAntibacklash_reg <= `OPC_RST_ANTIBACKLASH_LOCK;
        end else if (ioUpdate) begin
            actPumpControl_reg <= bufPumpControl_reg;
            actOffsetControl_reg <= bufOffsetControl_reg;
            actAntibacklash_reg <= bufAntibacklash_reg;
        end
    end

    // ======================================================================
    // Read back
    reg [7:0] rdData_next;
    reg rdHit_next;

    // Unmapped reads return zero so software never sees a stale byte
    always @* begin
        rdData_next = `OPC_READ_ZERO;
        rdHit_next = 1'b1;
        case (accessIndex)
            `OPC_IDX_PUMP_CONTROL: begin
                rdData_next = readBuffered ? bufPumpControl_reg : actPumpControl_reg;
            end
            `OPC_IDX_PUMP_OFFSET: begin
                rdData_next = readBuffered ? bufOffsetControl_reg : actOffsetControl_reg;
            end
            `OPC_IDX_ANTIBACKLASH: begin
                rdData_next = readBuffered ? bufAntibacklash_reg : actAntibacklash_reg;
            end
            default: begin
                rdHit_next = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            regRdData <= `OPC_READ_ZERO;
            regAddrHit <= 1'b0;
        end else if (regRdEn) begin
            regRdData <= rdData_next;
            regAddrHit <= rdHit_next;
        end
    end

    // ======================================================================
    // Override selection
    // Auto values pass straight through until software claims a field
    wire [1:0] modeSel;
    wire [2:0] offsetSel;
    wire [1:0] ablSel;

    opc_override_mux #(.WIDTH(2)) u_mode_mux (
        .overrideEnable(actPumpControl_reg[`OPC_PC_MODE_EN]),
        .softwareValue(actPumpControl_reg[`OPC_PC_MODE_HI:`OPC_PC_MODE_LO]),
        .autoValue(autoPumpMode),
        .selectedValue(modeSel)
    );

    opc_override_mux #(.WIDTH(3)) u_offset_mux (
        .overrideEnable(actOffsetControl_reg[`OPC_OC_EN]),
        .softwareValue(actOffsetControl_reg[`OPC_OC_DIR:`OPC_OC_FRAC_LO]),
        .autoValue({autoOffsetDirection, autoOffsetFraction}),
        .selectedValue(offsetSel)
    );

    opc_override_mux #(.WIDTH(2)) u_abl_mux (
        .overrideEnable(actPumpControl_reg[`OPC_PC_ABL_EN]),
        .softwareValue(actAntibacklash_reg[`OPC_AL_PERIOD_HI:`OPC_AL_PERIOD_LO]),
        .autoValue(autoAntibacklashPeriod),
        .selectedValue(ablSel)
    );

    // ======================================================================
    // Registered analog controls
    // One cycle behind the active copy; analog settling dwarfs it.
    always @(posedge ref_clk) begin
        if (rst) begin
            pump_operating_mode <= `OPC_MODE_NORMAL;
            pumpCurrentOverrideEnable <= 1'b0;
            feedbackEdgeFalling <= 1'b0;
            referenceEdgeFalling <= 1'b0;
            vcoForceMidscale <= 1'b0;
            pump_offset_direction <= 1'b0;
            pump_offset_fraction <= `OPC_FRAC_HALF;
            pfdUpDiv2Enable <= 1'b0;
            pfdDownDiv2Enable <= 1'b0;
            feedbackDiv2Enable <= 1'b0;
            antibacklashPeriod <= `OPC_ABL_MINIMUM;
            lockDetectPowerDown <= 1'b0;
        end else begin
            pump_operating_mode <= modeSel;
            pumpCurrentOverrideEnable <= actPumpControl_reg[`OPC_PC_CURRENT_EN];
            feedbackEdgeFalling <= actPumpControl_reg[`OPC_PC_FB_EDGE];
            referenceEdgeFalling <= actPumpControl_reg[`OPC_PC_REF_EDGE];
            vcoForceMidscale <= actPumpControl_reg[`OPC_PC_VCO_MID];
            pump_offset_direction <= offsetSel[`OPC_SEL_DIR];
            pump_offset_fraction <= offsetSel[`OPC_SEL_FRAC_HI:`OPC_SEL_FRAC_LO];
            pfdUpDiv2Enable <= actOffsetControl_reg[`OPC_OC_UP_DIV2];
            pfdDownDiv2Enable <= actOffsetControl_reg[`OPC_OC_DN_DIV2];
            feedbackDiv2Enable <= actOffsetControl_reg[`OPC_OC_FB_DIV2];
            antibacklashPeriod <= ablSel;
            lockDetectPowerDown <= actAntibacklash_reg[`OPC_AL_LOCK_PD];
        end
    end

endmodule // opc_pump_ctrl

`default_nettype wire

/* testbench/opc_pump_ctrl_sva.sv */
// Checker for the PFD and charge pump control registers
`timescale 1ns/10ps
`default_nettype none
`include "opc_pump_ctrl_map.vh"
module opc_pump_ctrl_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register access
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic readBuffered,
    input wire logic ioUpdate,
    input wire logic [7:0] regRdData,
    input wire logic regAddrHit,
    // Device settings
    input wire logic [1:0] autoPumpMode,
    input wire logic autoOffsetDirection,
    input wire logic [1:0] autoOffsetFraction,
    input wire logic [1:0] autoAntibacklashPeriod,
    // Analog controls
    input wire logic [1:0] pump_operating_mode,
    input wire logic pumpCurrentOverrideEnable,
    input wire logic feedbackEdgeFalling,
    input wire logic referenceEdgeFalling,
    input wire logic vcoForceMidscale,
    input wire logic pump_offset_direction,
    input wire logic [1:0] pump_offset_fraction,
    input wire logic pfdUpDiv2Enable,
    input wire logic pfdDownDiv2Enable,
    input wire logic feedbackDiv2Enable,
    input wire logic [1:0] antibacklashPeriod,
    input wire logic lockDetectPowerDown
);
    // ==========================================
    // Shadow copies, rebuilt from port traffic
    logic [7:0] bufB, bufC, bufD, actB, actC, actD, rdExp;
    logic mapped;
    logic [1:0] expMode, expAbl;
    logic [2:0] expOff;
    assign mapped = regAddr == 8'h0B || regAddr == 8'h0C || regAddr == 8'h0D;
    assign rdExp = !mapped ? 8'h00 : regAddr[1:0] == 2'b11 ? (readBuffered ? bufB : actB) :
        regAddr[0] ? (readBuffered ? bufD : actD) : (readBuffered ? bufC : actC);
    assign expMode = actB[3] ? actB[5:4] : autoPumpMode;
    assign expOff = actC[3] ? actC[6:4] : {autoOffsetDirection, autoOffsetFraction};
    assign expAbl = actB[6] ? actD[7:6] : autoAntibacklashPeriod;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {bufB, bufC, bufD} <= {`OPC_RST_PUMP_CONTROL, 16'h0000};
            {actB, actC, actD} <= {`OPC_RST_PUMP_CONTROL, 16'h0000};
        end else begin
            // Commit takes the old buffer, never a same-edge write
            if (ioUpdate) {actB, actC, actD} <= {bufB, bufC, bufD};
            if (regWrEn && regAddr == 8'h0B) bufB <= regWrData;
            if (regWrEn && regAddr == 8'h0C) bufC <= regWrData & `OPC_MASK_PUMP_OFFSET_CONTROL;
            if (regWrEn && regAddr == 8'h0D) bufD <= regWrData & `OPC_MASK_ANTIBACKLASH_LOCK;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_read;
        regRdEn && !rst;
    endsequence
    a_rd_data: assert property (s_read |=> regRdData == $past(rdExp) && regAddrHit == $past(mapped))
        else $error("read data or hit wrong");
    a_rd_hold: assert property (!regRdEn && !rst |=> $stable(regRdData) && $stable(regAddrHit))
        else $error("read data moved without a read");
    a_reset_vals: assert property (disable iff (1'b0) rst ##1 rst |-> pump_operating_mode == 2'h3
        && antibacklashPeriod == 2'h0 && !lockDetectPowerDown && !vcoForceMidscale)
        else $error("reset outputs wrong");
    a_mode_sel: assert property (!rst |=> pump_operating_mode == $past(expMode))
        else $error("pump mode wrong");
    a_edge_mid: assert property (!rst |=> {feedbackEdgeFalling, referenceEdgeFalling, vcoForceMidscale}
        == $past(actB[2:0]) && pumpCurrentOverrideEnable == $past(actB[7]))
        else $error("edge or midscale wrong");
    a_offset_sel: assert property (!rst |=> {pump_offset_direction, pump_offset_fraction} == $past(expOff))
        else $error("offset setting wrong");
    a_test_div: assert property (!rst |=> {pfdUpDiv2Enable, pfdDownDiv2Enable, feedbackDiv2Enable}
        == $past(actC[2:0]))
        else $error("test divider wrong");
    a_abl_sel: assert property (!rst |=> antibacklashPeriod == $past(expAbl))
        else $error("antibacklash wrong");
    a_lock_pd: assert property (!rst |=> lockDetectPowerDown == $past(actD[0]))
        else $error("lock detect power wrong");
    // Outputs not taken from auto values only move one edge after a commit
    sequence s_no_commit;
        !ioUpdate ##1 1'b1;
    endsequence
    a_commit_only: assert property (s_no_commit |=> $stable({feedbackEdgeFalling, referenceEdgeFalling,
        vcoForceMidscale, pfdUpDiv2Enable, pfdDownDiv2Enable, feedbackDiv2Enable, lockDetectPowerDown}))
        else $error("control moved without a commit");
endmodule // opc_pump_ctrl_sva
bind opc_pump_ctrl opc_pump_ctrl_sva i_sva (
    .ref_clk(ref_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .readBuffered(readBuffered),
    .ioUpdate(ioUpdate),
    .regRdData(regRdData),
    .regAddrHit(regAddrHit),
    .autoPumpMode(autoPumpMode),
    .autoOffsetDirection(autoOffsetDirection),
    .autoOffsetFraction(autoOffsetFraction),
    .autoAntibacklashPeriod(autoAntibacklashPeriod),
    .pump_operating_mode(pump_operating_mode),
    .pumpCurrentOverrideEnable(pumpCurrentOverrideEnable),
    .feedbackEdgeFalling(feedbackEdgeFalling),
    .referenceEdgeFalling(referenceEdgeFalling),
    .vcoForceMidscale(vcoForceMidscale),
    .pump_offset_direction(pump_offset_direction),
    .pump_offset_fraction(pump_offset_fraction),
    .pfdUpDiv2Enable(pfdUpDiv2Enable),
    .pfdDownDiv2Enable(pfdDownDiv2Enable),
    .feedbackDiv2Enable(feedbackDiv2Enable),
    .antibacklashPeriod(antibacklashPeriod),
    .lockDetectPowerDown(lockDetectPowerDown)
);
`default_nettype wire

/* testbench/opc_pump_ctrl_tb.sv */
// Self-checking bench for the PFD and charge pump control registers
`timescale 1ns/10ps
`default_nettype none
module opc_pump_ctrl_tb;
    logic ref_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, readBuffered = 0, ioUpdate = 0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
    logic [1:0] autoPumpMode = 2'h2, autoOffsetFraction = 2'h1, autoAntibacklashPeriod = 2'h3;
    logic autoOffsetDirection = 1;
    wire [7:0] regRdData;
    wire regAddrHit, curEn, fbEdge, refEdge, midscale, offDir, upDiv, dnDiv, fbDiv, lockPd;
    wire [1:0] mode, offFrac, abl;
    int failures = 0, compares = 0;
    opc_pump_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .readBuffered(readBuffered), .ioUpdate(ioUpdate),
        .regRdData(regRdData), .regAddrHit(regAddrHit), .autoPumpMode(autoPumpMode),
        .autoOffsetDirection(autoOffsetDirection), .autoOffsetFraction(autoOffsetFraction),
        .autoAntibacklashPeriod(autoAntibacklashPeriod), .pump_operating_mode(mode),
        .pumpCurrentOverrideEnable(curEn), .feedbackEdgeFalling(fbEdge), .referenceEdgeFalling(refEdge),
        .vcoForceMidscale(midscale), .pump_offset_direction(offDir), .pump_offset_fraction(offFrac),
        .pfdUpDiv2Enable(upDiv), .pfdDownDiv2Enable(dnDiv), .feedbackDiv2Enable(fbDiv),
        .antibacklashPeriod(abl), .lockDetectPowerDown(lockPd));
    // ==========================================
    // Access tasks
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk) {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(posedge ref_clk) regWrEn <= 0;
    endtask
    task automatic rd(input logic [7:0] a, e, input logic h);
        @(posedge ref_clk) {regAddr, regRdEn} <= {a, 1'b1};
        @(posedge ref_clk) regRdEn <= 0;
        @(negedge ref_clk) chk({7'h00, regAddrHit}, {7'h00, h});
        chk(regRdData, e);
    endtask
    // Outputs lag the commit by one edge, so wait for it
    task automatic upd;
        @(posedge ref_clk) ioUpdate <= 1;
        @(posedge ref_clk) ioUpdate <= 0;
        @(posedge ref_clk) #1;
    endtask
    task automatic summarize;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 0;
        rd(8'h0B, 8'h30, 1);
        rd(8'h0C, 8'h00, 1);
        rd(8'h0D, 8'h00, 1);
        rd(8'h0A, 8'h00, 0);
        chk(mode, autoPumpMode);
        wr(8'h0B, 8'h3F);
        readBuffered <= 1;
        rd(8'h0B, 8'h3F, 1);
        @(posedge ref_clk) readBuffered <= 0;
        rd(8'h0B, 8'h30, 1);
        upd;
        chk({mode, fbEdge, refEdge, midscale}, 5'h1F);
        for (int m = 0; m < 4; m++) begin
            wr(8'h0B, {2'b00, m[1:0], 1'b1, m[0], m[1], ~m[0]});
            upd;
            chk({mode, fbEdge, refEdge, midscale}, {m[1:0], m[0], m[1], ~m[0]});
        end
        wr(8'h0B, 8'hC0);
        upd;
        chk({curEn, mode}, {1'b1, autoPumpMode});
        @(posedge ref_clk) autoPumpMode <= 2'h1;
        @(posedge ref_clk) #1;
        chk(mode, 2'h1);
        wr(8'h0C, 8'hFF);
        upd;
        rd(8'h0C, 8'h7F, 1);
        chk({offDir, offFrac, upDiv, dnDiv, fbDiv}, 6'h3F);
        for (int f = 0; f < 4; f++) begin
            wr(8'h0C, {1'b0, f[0], f[1:0], 1'b1, f[0], ~f[0], f[1]});
            upd;
            chk({offDir, offFrac, upDiv, dnDiv, fbDiv}, {f[0], f[1:0], f[0], ~f[0], f[1]});
        end
        wr(8'h0C, 8'h77);
        upd;
        chk({offDir, offFrac, upDiv, dnDiv, fbDiv}, {autoOffsetDirection, autoOffsetFraction, 3'h7});
        for (int p = 0; p < 4; p++) begin
            wr(8'h0D, {p[1:0], 6'h3F});
            upd;
            rd(8'h0D, {p[1:0], 6'h01}, 1);
            chk({abl, lockPd}, {p[1:0], 1'b1});
        end
        wr(8'h0E, 8'hFF);
        rd(8'h0E, 8'h00, 0);
        wr(8'h0B, 8'h00);
        wr(8'h0D, 8'h00);
        upd;
        chk({abl, lockPd, curEn}, {autoAntibacklashPeriod, 2'b00});
        summarize();
    end
    // Whole run is under two hundred cycles
    initial begin
        #20000;
        failures++;
        summarize();
    end
endmodule // opc_pump_ctrl_tb
`default_nettype wire
